// [mat_ctrl_model.sv]
// Model of the remote controller that sends command pulses.
// Assumes the block takes each command at a rising edge of the shared clock.
`timescale 1ns/1ns
module mat_ctrl_model (
  // Clock.
  input  wire logic clock,
  // Pulses: abort, reset, recall, initiate, acquire, common, group.
  output logic [6:0] cmd
);
  // Nothing is pending until the bench asks for a command.
  initial cmd = 7'h00;
  // One pulse of one cycle; the caller sends a fresh initiate for every capture.
  task automatic send(input int code);
    @(posedge clock);
    cmd[code] <= 1'b1;
    @(posedge clock);
    cmd[code] <= 1'b0;
  endtask
endmodule

// [mat_pkg.sv]
// Types shared by the measurement acquisition trigger modules.
// Assumes mat_regs.svh is on the include path.
`include "mat_regs.svh"

package mat_pkg;

  typedef enum logic [1:0] {
    MAT_IDLE,
    MAT_INITIATED,
    MAT_ACQUIRING
  } mat_state_t;

  typedef logic [`MAT_ADDR_W-1:0]   mat_addr_t;
  typedef logic [`MAT_SAMPLE_W-1:0] mat_sample_t;

endpackage

// [mat_regs.svh]
// Constants for the measurement acquisition trigger block.
// Included by the package and the design modules; holds definitions only.
`ifndef MAT_REGS_SVH
`define MAT_REGS_SVH

// Buffer geometry and sample widths.
`define MAT_DEPTH            4096
`define MAT_ADDR_W           12
`define MAT_SAMPLE_W         18

// Minimum sample periods in nanoseconds, first and later generation.
`define MAT_PER_1PH_GEN1_NS  25600
`define MAT_PER_1PH_GEN2_NS  10400
`define MAT_PER_3PH_GEN1_NS  76800
`define MAT_PER_3PH_GEN2_NS  31200
`define MAT_CLK_NS           10

// Sample interval multiplier limits.
`define MAT_INTERVAL_MAX     4'h0_A
`define MAT_INTERVAL_RST     4'h0_1

// Offset limits in milliseconds.
`define MAT_OFFSET_MAX_MS    1000
`define MAT_OFFSET_W         20

// Trigger source encodings.
`define MAT_SRC_IMMEDIATE    2'h0
`define MAT_SRC_PHASE        2'h1
`define MAT_SRC_BUS          2'h2
`define MAT_SRC_TRANSIENT    2'h3

// Standard event bit for power on.
`define MAT_PON_BIT          7

`endif

// [mat_sample_tick.sv]
// Sample pacing for the acquisition buffer.
// Assumes one clock of 100 MHz; the period select is stable while acquiring.
`timescale 1ns/1ns
`include "mat_regs.svh"

module mat_sample_tick
  import mat_pkg::*;
(
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       reset_n,
  // Period selection.
  input  wire logic       three_phase,
  input  wire logic       later_gen,
  input  wire logic [3:0] interval_mult,
  // Sample strobe.
  output logic            sample_tick
);

  localparam int P1G1 = `MAT_PER_1PH_GEN1_NS / `MAT_CLK_NS;
  localparam int P1G2 = `MAT_PER_1PH_GEN2_NS / `MAT_CLK_NS;
  localparam int P3G1 = `MAT_PER_3PH_GEN1_NS / `MAT_CLK_NS;
  localparam int P3G2 = `MAT_PER_3PH_GEN2_NS / `MAT_CLK_NS;

  logic [16:0] base_cycles;
  logic [16:0] period_cycles;
  logic [16:0] count_reg;

  // Minimum period in clocks, stretched by the interval multiplier.
  // Seventeen bits, since ten times the slowest minimum period passes 16 bits.
  always_comb begin
    if (three_phase) begin
      base_cycles = later_gen ? 17'(P3G2) : 17'(P3G1);
    end else begin
      base_cycles = later_gen ? 17'(P1G2) : 17'(P1G1);
    end
    period_cycles = 17'(base_cycles * {13'h0_000, interval_mult});
  end

  // Free-running divider; a strobe marks each sample instant.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_reg   <= 17'h0_0000;
      sample_tick <= 1'b0;
    end else if (count_reg >= period_cycles - 17'h0_0001) begin
      count_reg   <= 17'h0_0000;
      sample_tick <= 1'b1;
    end else begin
      count_reg   <= count_reg + 17'h0_0001;
      sample_tick <= 1'b0;
    end
  end

endmodule

// [mat_trigger.sv]
// Measurement acquisition trigger controller with capture buffers.
// Assumes commands arrive as one-cycle pulses decoded from the remote
// interface on this clock; phase and transient pulse come from other clocks.
//
// Overview of operation
// - After power-up sit idle and discard every trigger.
// - Abort, reset or recall forces the machine back to idle.
// - Initiate moves idle to initiated, where selected-source triggers are accepted.
// - After trigger and full capture return idle; controller re-initiates each time.
// - No continuous re-arm; captured data is never overwritten automatically.
// - Source is immediate, phase sync, bus or transient pulse.
// - Bus source accepts acquire-trigger, common trigger or group execute trigger.
// - Phase source fires when the phase reference reaches the programmed angle.
// - Voltage and current are 18-bit samples, 4096 per waveform.
// - Minimum period 25.6/10.4 us single phase, 76.8/31.2 us three phase.
// - Interval is one to ten times the minimum, readable by query.
// - Negative offset keeps pre-trigger samples, positive delays first stored sample.
// - Post-trigger delay equals offset count times the sample period.
// - Offset runs from minus one full buffer up to 1000 ms; only the negative end is clamped, positive counts are not limited.
// - With both systems armed, acquisition takes first trigger, transient second.
// - Fetch reads the captured buffer without starting a new acquisition.
// - In three-phase mode phase select 1 to 3 picks fetched data.
// - Array reads return all 4096 samples in buffer order.
// - At power-up clear every status data and enable bit; here the event bit is set and the mask loaded from the setting after reset.
// - Power-on clear setting is kept and recalled, letting power-on raise service.
`timescale 1ns/1ns
`include "mat_regs.svh"

module mat_trigger
  import mat_pkg::*;
(
  // Clock and reset.
  input  wire logic                      clock,
  input  wire logic                      reset_n,
  // Commands, one-cycle pulses.
  input  wire logic                      cmd_abort,
  input  wire logic                      cmd_reset,
  input  wire logic                      cmd_recall,
  input  wire logic                      cmd_initiate,
  input  wire logic                      cmd_acq_trigger,
  input  wire logic                      cmd_common_trigger,
  input  wire logic                      cmd_group_trigger,
  // Configuration.
  input  wire logic [1:0]                trigger_source,
  input  wire logic [8:0]                sync_angle,
  input  wire logic [3:0]                interval_mult,
  input  wire logic                      three_phase,
  input  wire logic                      later_gen,
  input  wire logic signed [`MAT_OFFSET_W-1:0] trigger_offset,
  input  wire logic [1:0]                phase_select,
  input  wire logic                      power_on_clear_setting,
  // Inputs from other domains; transient_armed is used without a synchroniser.
  input  wire logic [8:0]                phase_angle,
  input  wire logic                      transient_pulse_source,
  input  wire logic                      transient_armed,
  // Sample inputs, one set per phase.
  input  wire logic [3*`MAT_SAMPLE_W-1:0] volt_in,
  input  wire logic [3*`MAT_SAMPLE_W-1:0] curr_in,
  // Fetch port.
  input  wire logic                      fetch_req,
  input  wire logic [`MAT_ADDR_W-1:0]    fetch_addr,
  output logic [`MAT_SAMPLE_W-1:0]       fetch_volt,
  output logic [`MAT_SAMPLE_W-1:0]       fetch_curr,
  output logic                           fetch_valid,
  // Status.
  output mat_state_t                     state,
  output logic [3:0]                     sample_interval_query,
  output logic                           acq_complete,
  output logic                           transient_trigger,
  output logic                           power_on_event_bit,
  output logic                           power_on_mask,
  output logic                           service_request
);

  localparam int DEPTH = `MAT_DEPTH;

  // Capture arrays, one per phase and quantity.
  mat_sample_t volt_mem [3][DEPTH];
  mat_sample_t curr_mem [3][DEPTH];

  mat_state_t  state_next;
  logic [1:0]  pulse_sync_reg;
  logic        pulse_last_reg;
  logic [8:0]  angle_meta_reg;
  logic [8:0]  angle_sync_reg;
  logic [8:0]  angle_last_reg;
  logic        sample_tick;
  logic        trig_event;
  logic        accepted;
  logic        go_idle;
  logic        pulse_rise;
  logic        angle_hit;
  mat_addr_t   wr_ptr_reg;
  logic [12:0] count_reg;
  logic signed [`MAT_OFFSET_W:0] delay_reg;
  logic        por_done_reg;
  logic [3:0]  interval_reg;
  logic [1:0]  phase_idx;

  // Clamp helper for the interval multiplier.
  function automatic logic [3:0] clamp_mult(input logic [3:0] m);
    if (m == 4'h0_0) begin
      clamp_mult = `MAT_INTERVAL_RST;
    end else if (m > `MAT_INTERVAL_MAX) begin
      clamp_mult = `MAT_INTERVAL_MAX;
    end else begin
      clamp_mult = m;
    end
  endfunction

  // Two-stage synchronisers for signals from other clocks.
  // Limitation: the angle is a multi-bit word, so its source must step it by
  // single counts on a related clock; a skewed word could miss the set angle.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pulse_sync_reg <= 2'h0;
      pulse_last_reg <= 1'b0;
      angle_meta_reg <= 9'h0_00;
      angle_sync_reg <= 9'h0_00;
      angle_last_reg <= 9'h0_00;
    end else begin
      pulse_sync_reg <= {pulse_sync_reg[0], transient_pulse_source};
      pulse_last_reg <= pulse_sync_reg[1];
      angle_meta_reg <= phase_angle;
      angle_sync_reg <= angle_meta_reg;
      angle_last_reg <= angle_sync_reg;
    end
  end

  assign pulse_rise = pulse_sync_reg[1] && !pulse_last_reg;
  // Crossing the programmed angle, including the wrap from 359 back to 0.
  assign angle_hit  = (angle_sync_reg == sync_angle) ||
                      ((angle_last_reg < sync_angle) && (angle_sync_reg > sync_angle)) ||
                      ((angle_sync_reg < angle_last_reg) && (angle_sync_reg >= sync_angle)
                       && (sync_angle == 9'h0_00));

  // Source selection; bus accepts any of three events.
  always_comb begin
    case (trigger_source)
      `MAT_SRC_IMMEDIATE: trig_event = 1'b1;
      `MAT_SRC_PHASE:     trig_event = angle_hit;
      `MAT_SRC_BUS:       trig_event = cmd_acq_trigger || cmd_common_trigger
                                       || cmd_group_trigger;
      `MAT_SRC_TRANSIENT: trig_event = pulse_rise;
      default:            trig_event = 1'b0;
    endcase
  end

  assign go_idle  = cmd_abort || cmd_reset || cmd_recall;
  // Triggers outside the initiated state are dropped.
  assign accepted = (state == MAT_INITIATED) && trig_event && !go_idle;
  // The acquisition system claims the trigger; the transient one sees only the next.
  assign transient_trigger = transient_armed && trig_event && !accepted;

  // Interval register, latched at initiate so it holds steady during capture.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      interval_reg <= `MAT_INTERVAL_RST;
    end else if (cmd_reset) begin
      interval_reg <= `MAT_INTERVAL_RST;
    end else if (state == MAT_IDLE && cmd_initiate) begin
      interval_reg <= clamp_mult(interval_mult);
    end
  end

  assign sample_interval_query = interval_reg;

  mat_sample_tick u_tick (
    .clock         (clock),
    .reset_n       (reset_n),
    .three_phase   (three_phase),
    .later_gen     (later_gen),
    .interval_mult (interval_reg),
    .sample_tick   (sample_tick)
  );

  // State machine; no path leads from idle back to capture without initiate.
  always_comb begin
    state_next = state;
    case (state)
      MAT_IDLE: begin
        if (cmd_initiate && !go_idle) begin
          state_next = MAT_INITIATED;
        end
      end
      MAT_INITIATED: begin
        if (go_idle) begin
          state_next = MAT_IDLE;
        end else if (accepted) begin
          state_next = MAT_ACQUIRING;
        end
      end
      MAT_ACQUIRING: begin
        if (go_idle) begin
          state_next = MAT_IDLE;
        end else if (count_reg == 13'(DEPTH)) begin
          state_next = MAT_IDLE;
        end
      end
      default: state_next = MAT_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= MAT_IDLE;
    end else begin
      state <= state_next;
    end
  end

  // Capture bookkeeping. Pre-trigger history is gathered while initiated,
  // so a negative offset can only reach back as far as the armed time allows.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg     <= '0;
      count_reg      <= 13'h0_000;
      delay_reg      <= '0;
      acq_complete   <= 1'b0;
    end else begin
      acq_complete <= 1'b0;
      if (state == MAT_IDLE) begin
        count_reg <= 13'h0_000;
      end
      if (state == MAT_INITIATED && accepted) begin
        // A sample taken on the trigger edge is kept, so the pointer moves on.
        if (sample_tick) begin
          wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
        if (trigger_offset < 0) begin
          // Keep the newest pre-trigger samples at the record start; an offset
          // beyond one whole buffer is clamped and leaves nothing to capture.
          count_reg <= (trigger_offset < -DEPTH) ? 13'(DEPTH) : 13'(-trigger_offset);
          acq_complete <= (trigger_offset <= -DEPTH);
          delay_reg <= '0;
        end else begin
          count_reg <= 13'h0_000;
          delay_reg <= (`MAT_OFFSET_W+1)'(trigger_offset);
        end
      end else if (state == MAT_ACQUIRING && sample_tick) begin
        if (delay_reg > 0) begin
          delay_reg <= delay_reg - 1'b1;
        end else begin
          wr_ptr_reg <= wr_ptr_reg + 1'b1;
          count_reg  <= count_reg + 13'h0_001;
          if (count_reg == 13'(DEPTH - 1)) begin
            acq_complete <= 1'b1;
          end
        end
      end else if (state == MAT_INITIATED && sample_tick) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
    end
  end

  // Sample writes; nothing is written while idle, so data survives fetches.
  always_ff @(posedge clock) begin
    if (sample_tick && (state == MAT_INITIATED ||
        (state == MAT_ACQUIRING && delay_reg == 0 && count_reg < 13'(DEPTH)))) begin
      for (int p = 0; p < 3; p++) begin
        volt_mem[p][wr_ptr_reg] <= volt_in[p*`MAT_SAMPLE_W +: `MAT_SAMPLE_W];
        curr_mem[p][wr_ptr_reg] <= curr_in[p*`MAT_SAMPLE_W +: `MAT_SAMPLE_W];
      end
    end
  end

  // Phase select maps 1..3 to the array index; single phase always uses phase one.
  assign phase_idx = (three_phase && phase_select != 2'h0) ? phase_select - 2'h1 : 2'h0;

  // Fetch reads in buffer order starting at the oldest sample.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fetch_volt  <= '0;
      fetch_curr  <= '0;
      fetch_valid <= 1'b0;
    end else begin
      fetch_valid <= fetch_req && state == MAT_IDLE;
      if (fetch_req && state == MAT_IDLE) begin
        fetch_volt <= volt_mem[phase_idx][wr_ptr_reg + fetch_addr];
        fetch_curr <= curr_mem[phase_idx][wr_ptr_reg + fetch_addr];
      end
    end
  end

  // Power-on status: event and mask are cleared, then the event is set and the
  // stored setting loads the mask one cycle after release.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      power_on_event_bit <= 1'b0;
      power_on_mask      <= 1'b0;
      por_done_reg       <= 1'b0;
    end else if (!por_done_reg) begin
      por_done_reg           <= 1'b1;
      power_on_event_bit     <= 1'b1;
      power_on_mask          <= power_on_clear_setting;
    end else if (cmd_reset) begin
      power_on_event_bit <= 1'b0;
    end
  end

  assign service_request = power_on_event_bit && power_on_mask;

endmodule

// [mat_trigger_asserts.sv]
// Checker for the acquisition trigger controller.
// Assumes it is bound to mat_trigger and sees only that module's ports.
`timescale 1ns/1ns
`include "mat_regs.svh"
module mat_trigger_chk
  import mat_pkg::*;
(
  // Clock and reset.
  input wire logic       clock,
  input wire logic       reset_n,
  // Commands and configuration.
  input wire logic       cmd_abort,
  input wire logic       cmd_reset,
  input wire logic       cmd_recall,
  input wire logic       cmd_initiate,
  input wire logic       cmd_acq_trigger,
  input wire logic       cmd_common_trigger,
  input wire logic       cmd_group_trigger,
  input wire logic [1:0] trigger_source,
  input wire logic       fetch_req,
  // Observed outputs.
  input wire mat_state_t state,
  input wire logic [3:0] sample_interval_query,
  input wire logic       acq_complete,
  input wire logic       transient_trigger,
  input wire logic       fetch_valid
);
  // Stop and bus trigger events folded into single terms.
  wire logic stop_any = cmd_abort | cmd_reset | cmd_recall;
  wire logic bus_any = cmd_acq_trigger | cmd_common_trigger | cmd_group_trigger;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_stop; stop_any |=> state == MAT_IDLE; endproperty
  a_stop: assert property (p_stop) else $error("stop did not reach idle");
  property p_idle; state == MAT_IDLE && !cmd_initiate |=> state == MAT_IDLE; endproperty
  a_idle: assert property (p_idle) else $error("left idle without initiate");
  property p_init; state == MAT_IDLE && cmd_initiate && !stop_any |=> state == MAT_INITIATED;
  endproperty
  a_init: assert property (p_init) else $error("initiate did not arm");
  property p_bus_fire;
    state == MAT_INITIATED && trigger_source == `MAT_SRC_BUS && bus_any && !stop_any
    |=> state == MAT_ACQUIRING;
  endproperty
  a_bus_fire: assert property (p_bus_fire) else $error("bus trigger missed");
  property p_bus_wait;
    state == MAT_INITIATED && trigger_source == `MAT_SRC_BUS && !bus_any && !stop_any
    |=> state == MAT_INITIATED;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("armed state left early");
  property p_imm;
    state == MAT_INITIATED && trigger_source == `MAT_SRC_IMMEDIATE && !stop_any
    |=> state == MAT_ACQUIRING;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate source did not fire");
  property p_hold;
    state == MAT_ACQUIRING && !acq_complete && !stop_any |=> state == MAT_ACQUIRING;
  endproperty
  a_hold: assert property (p_hold) else $error("capture ended early");
  property p_done; acq_complete |=> state == MAT_IDLE; endproperty
  a_done: assert property (p_done) else $error("no idle after capture");
  property p_fetch_ok; fetch_req && state == MAT_IDLE |=> fetch_valid; endproperty
  a_fetch_ok: assert property (p_fetch_ok) else $error("idle fetch unanswered");
  property p_fetch_busy; fetch_req && state != MAT_IDLE |=> !fetch_valid; endproperty
  a_fetch_busy: assert property (p_fetch_busy) else $error("busy fetch answered");
  property p_interval; sample_interval_query inside {[4'h1:`MAT_INTERVAL_MAX]}; endproperty
  a_interval: assert property (p_interval) else $error("interval out of range");
  property p_prio;
    state == MAT_INITIATED && trigger_source == `MAT_SRC_TRANSIENT |-> !transient_trigger;
  endproperty
  a_prio: assert property (p_prio) else $error("transient took armed trigger");
  // Main scenarios reached.
  c_acq: cover property (state == MAT_ACQUIRING);
  c_fetch: cover property (fetch_valid);
  c_trans: cover property (transient_trigger);
endmodule

bind mat_trigger mat_trigger_chk i_chk (
  .clock(clock), .reset_n(reset_n), .cmd_abort(cmd_abort), .cmd_reset(cmd_reset),
  .cmd_recall(cmd_recall), .cmd_initiate(cmd_initiate), .cmd_acq_trigger(cmd_acq_trigger),
  .cmd_common_trigger(cmd_common_trigger), .cmd_group_trigger(cmd_group_trigger),
  .trigger_source(trigger_source), .fetch_req(fetch_req), .state(state),
  .sample_interval_query(sample_interval_query), .acq_complete(acq_complete),
  .transient_trigger(transient_trigger), .fetch_valid(fetch_valid));

// [test_measurement_acquisition_trigger.sv]
// Bench for the acquisition trigger controller.
// Assumes mat_ctrl_model sends the commands and the checker is bound.
`timescale 1ns/1ns
`include "mat_regs.svh"
module test_measurement_acquisition_trigger
  import mat_pkg::*;
;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic [6:0]  cmd;
  logic [1:0]  trigger_source = `MAT_SRC_BUS;
  logic [8:0]  sync_angle = 9'h000;
  logic [8:0]  phase_angle = 9'h000;
  logic [3:0]  interval_mult = 4'h1;
  logic [53:0] volt_in = 54'h0;
  logic [53:0] curr_in = 54'h0;
  logic        transient_pulse_source = 1'b0;
  logic        transient_armed = 1'b0;
  logic        fetch_req = 1'b0;
  logic        three_phase = 1'b0;
  logic        later_gen = 1'b0;
  logic        power_on_clear_setting = 1'b1;
  logic [1:0]  phase_select = 2'h1;
  logic [11:0] fetch_addr = 12'h000;
  logic signed [19:0] trigger_offset = 20'h0_0000;
  logic [17:0] fetch_volt;
  logic [17:0] fetch_curr;
  logic        fetch_valid, acq_complete, transient_trigger, service_request;
  logic        power_on_event_bit, power_on_mask;
  logic [3:0]  sample_interval_query;
  mat_state_t  state;
  logic        tt_seen = 1'b0;
  int          mismatches = 0;
  int          samples_checked = 0;

  // Clock and moving sample data, so the buffer always sees fresh values.
  always #5 clock = ~clock;
  always @(posedge clock) begin
    volt_in <= volt_in + 54'h30_0008_0001; // Phase lanes ramp by 1, 2 and 3.
    curr_in <= curr_in + 54'h3;
    if (transient_trigger === 1'b1) tt_seen <= 1'b1;
  end

  mat_ctrl_model i_ctrl (.clock(clock), .cmd(cmd));
  mat_trigger i_dut (
    .clock(clock), .reset_n(reset_n), .cmd_abort(cmd[0]), .cmd_reset(cmd[1]),
    .cmd_recall(cmd[2]), .cmd_initiate(cmd[3]), .cmd_acq_trigger(cmd[4]),
    .cmd_common_trigger(cmd[5]), .cmd_group_trigger(cmd[6]),
    .trigger_source(trigger_source), .sync_angle(sync_angle),
    .interval_mult(interval_mult), .three_phase(three_phase), .later_gen(later_gen),
    .trigger_offset(trigger_offset), .phase_select(phase_select),
    .power_on_clear_setting(power_on_clear_setting),
    .phase_angle(phase_angle), .transient_pulse_source(transient_pulse_source),
    .transient_armed(transient_armed), .volt_in(volt_in), .curr_in(curr_in),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_volt(fetch_volt),
    .fetch_curr(fetch_curr), .fetch_valid(fetch_valid), .state(state),
    .sample_interval_query(sample_interval_query), .acq_complete(acq_complete),
    .transient_trigger(transient_trigger), .power_on_event_bit(power_on_event_bit),
    .power_on_mask(power_on_mask), .service_request(service_request));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Wait n edges, then let their updates settle.
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Bounded wait; running out is a mismatch and ends the run.
  task automatic wait_state(input mat_state_t s);
    int n;
    for (n = 0; n < 400 && state !== s; n++) tick(1);
    check("state reached", state, s);
    if (state !== s) end_sim();
  endtask

  task automatic fetch(input logic exp, input logic [11:0] a);
    @(posedge clock);
    fetch_req  <= 1'b1;
    fetch_addr <= a;
    @(posedge clock);
    fetch_req <= 1'b0;
    tick(0);
    check("fetch_valid", fetch_valid, exp);
  endtask

  task automatic t_reset();
    tick(4);
    check("mask in reset", power_on_mask, 1'b0);
    check("event in reset", power_on_event_bit, 1'b0);
    @(posedge clock);
    reset_n <= 1'b1;
    tick(1);
    check("power on event", power_on_event_bit, 1'b1);
    check("power on mask", power_on_mask, 1'b1);
    check("service request", service_request, 1'b1);
    check("reset state", state, MAT_IDLE);
    check("reset interval", sample_interval_query, 4'h1);
  endtask

  task automatic t_idle();
    int k;
    for (k = 4; k < 7; k++) begin
      i_ctrl.send(k);
      tick(0);
      check("idle trigger", state, MAT_IDLE);
    end
  endtask

  // Each bus trigger kind, each stop command, refused fetch mid-capture.
  task automatic t_bus();
    int k;
    for (k = 0; k < 3; k++) begin
      i_ctrl.send(3);
      tick(0);
      check("armed", state, MAT_INITIATED);
      tick(5);
      check("waiting", state, MAT_INITIATED);
      i_ctrl.send(4 + k);
      tick(0);
      check("bus fired", state, MAT_ACQUIRING);
      fetch(1'b0, 12'h000);
      tick(20);
      check("capturing", state, MAT_ACQUIRING);
      i_ctrl.send(k);
      tick(0);
      check("stopped", state, MAT_IDLE);
      tick(3);
      check("no rearm", state, MAT_IDLE);
    end
  endtask

  task automatic t_interval();
    logic [3:0] m [5] = '{4'h0, 4'h1, 4'h5, 4'hA, 4'hF};
    logic [3:0] e [5] = '{4'h1, 4'h1, 4'h5, 4'hA, 4'hA};
    int k;
    for (k = 0; k < 5; k++) begin
      @(posedge clock);
      interval_mult <= m[k];
      i_ctrl.send(3);
      tick(1);
      check("interval", sample_interval_query, e[k]);
      i_ctrl.send(2);
    end
  endtask

  task automatic t_imm();
    @(posedge clock);
    trigger_source <= `MAT_SRC_IMMEDIATE;
    tick(3);
    check("immediate idle", state, MAT_IDLE);
    i_ctrl.send(3);
    wait_state(MAT_ACQUIRING);
    i_ctrl.send(0);
  endtask

  // Sweep the phase reference; the fire point must follow the set angle.
  task automatic t_phase();
    int n;
    @(posedge clock);
    trigger_source <= `MAT_SRC_PHASE;
    sync_angle <= 9'h05A;
    i_ctrl.send(3);
    for (n = 0; n < 300 && state !== MAT_ACQUIRING; n++) begin
      @(posedge clock);
      phase_angle <= phase_angle + 9'h001;
      tick(0);
    end
    check("fire angle", phase_angle inside {[9'h05A:9'h064]}, 1'b1);
    i_ctrl.send(0);
  endtask

  task automatic t_trans();
    @(posedge clock);
    trigger_source <= `MAT_SRC_TRANSIENT;
    transient_armed <= 1'b1;
    i_ctrl.send(3);
    tick(0);
    tt_seen = 1'b0;
    @(posedge clock);
    transient_pulse_source <= 1'b1;
    wait_state(MAT_ACQUIRING);
    check("first to capture", tt_seen, 1'b0);
    transient_pulse_source <= 1'b0;
    i_ctrl.send(0);
    tick(3);
    @(posedge clock);
    transient_pulse_source <= 1'b1;
    tick(8);
    check("second to transient", tt_seen, 1'b1);
    transient_pulse_source <= 1'b0;
  endtask

  // Second power-up with the stored setting cleared: no service request.
  task automatic t_por();
    @(posedge clock);
    power_on_clear_setting <= 1'b0;
    reset_n                <= 1'b0;
    tick(5);
    check("state in reset", state, MAT_IDLE);
    @(posedge clock);
    reset_n <= 1'b1;
    tick(1);
    check("event after reset", power_on_event_bit, 1'b1);
    check("mask cleared", power_on_mask, 1'b0);
    check("no service", service_request, 1'b0);
  endtask

  // Nearly whole pre-trigger record, so capture ends one sample after the trigger;
  // the two newest samples must lie one programmed period apart.
  task automatic t_capture(input logic tp, input logic [1:0] ps, input logic [3:0] m,
                           input int lane, input int per);
    logic [17:0] v0;
    logic [17:0] v1;
    logic [17:0] c0;
    int n;
    @(posedge clock);
    trigger_source <= `MAT_SRC_BUS;
    later_gen      <= 1'b1;
    three_phase    <= tp;
    phase_select   <= ps;
    interval_mult  <= m;
    trigger_offset <= 20'hF_F001;
    i_ctrl.send(3);
    tick(2 * per + 8);
    i_ctrl.send(4);
    for (n = 0; n < 4000 && acq_complete !== 1'b1; n++) tick(1);
    check("capture done", acq_complete, 1'b1);
    if (acq_complete !== 1'b1) end_sim();
    tick(1);
    check("idle after capture", state, MAT_IDLE);
    fetch(1'b1, 12'hFFF);
    v1 = fetch_volt;
    fetch(1'b1, 12'hFFE);
    v0 = fetch_volt;
    c0 = fetch_curr;
    fetch(1'b1, 12'hFFF);
    check("refetch", fetch_volt, v1);
    check("volt step", 18'(fetch_volt - v0), 18'(lane * per));
    check("curr step", 18'(fetch_curr - c0), 18'(lane == 1 ? 3 * per : 0));
    check("no rearm after capture", state, MAT_IDLE);
  endtask

  initial begin
    t_reset();
    t_idle();
    fetch(1'b1, 12'h000);
    t_bus();
    t_interval();
    t_imm();
    t_phase();
    t_trans();
    t_por();
    t_capture(1'b0, 2'h3, 4'h2, 1, 2 * `MAT_PER_1PH_GEN2_NS / `MAT_CLK_NS);
    t_capture(1'b1, 2'h2, 4'h1, 2, `MAT_PER_3PH_GEN2_NS / `MAT_CLK_NS);
    end_sim();
  end
endmodule
